//--- hdl/wdt_core.sv
`timescale 1ns/10ps
`include "wdt_regs.svh"
module wdt_core
  import wdt_pkg::*;
#(
  parameter int CNT_W = 14,
  parameter int PRE_W = 7
) (
  input wire logic aclk,
  input wire logic aresetn,
  wdt_core_if.core cif
);
  logic [CNT_W-1:0] cnt_r;
  logic [PRE_W-1:0] pre_r;
  logic [6:0]       pulse_r;
  logic             armed_r;
  logic             wrap_r;
  logic             rst_pin_r;
  logic             step;
  logic             at_end;

  // Low bits of the prescaler that must be all ones to pass a tick
  function automatic logic [PRE_W-1:0] stage_mask(input logic [2:0] sel);
    stage_mask = PRE_W'((32'h1 << sel) - 32'h1);
  endfunction

  // Prescaled tick and terminal detect
  assign step   = cif.tick & ((pre_r & stage_mask(cif.presc)) == stage_mask(cif.presc));
  assign at_end = armed_r & (cnt_r == CNT_W'(`WDT_TERMINAL));

  // Armed flag: only reset or overflow clears it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      armed_r <= 1'b0;
    end else if (at_end) begin
      armed_r <= 1'b0;
    end else if (cif.key_done) begin
      armed_r <= 1'b1;
    end
  end

  // Prescaler and counter; a completed key restarts both
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_r <= '0;
      pre_r <= '0;
    end else if (at_end || cif.key_done) begin
      cnt_r <= '0;
      pre_r <= '0;
    end else if (armed_r && cif.tick) begin
      pre_r <= pre_r + PRE_W'(1);
      if (step) begin
        cnt_r <= cnt_r + CNT_W'(1);
      end
    end
  end

  // Reset pulse, timed in machine-cycle ticks
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pulse_r   <= 7'h0;
      rst_pin_r <= 1'b0;
    end else if (at_end) begin
      pulse_r   <= `WDT_PULSE_TICKS;
      rst_pin_r <= 1'b1;
    end else if (cif.tick && pulse_r != 7'h0) begin
      pulse_r <= pulse_r - 7'h1;
      if (pulse_r == 7'h1) begin
        rst_pin_r <= 1'b0;
      end
    end
  end

  // Overflow event for the status register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wrap_r <= 1'b0;
    end else begin
      wrap_r <= at_end;
    end
  end

  assign cif.armed   = armed_r;
  assign cif.wrap    = wrap_r;
  assign cif.rst_pin = rst_pin_r;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  stay_idle_a: assert property (!armed_r && !cif.key_done |=> !armed_r)
    else $error("watchdog armed without key");
  no_disarm_a: assert property (armed_r && !at_end |=> armed_r)
    else $error("watchdog left armed state");
  count_step_a: assert property (armed_r && step && !at_end && !cif.key_done
    |=> cnt_r == $past(cnt_r) + CNT_W'(1))
    else $error("counter did not advance");
  overflow_a: assert property (at_end |=> !armed_r && rst_pin_r && cnt_r == '0)
    else $error("overflow did not reset");
  pulse_len_a: assert property ($rose(rst_pin_r) |-> pulse_r == `WDT_PULSE_TICKS)
    else $error("reset pulse length wrong");
  presc_hold_a: assert property (armed_r && cif.tick && cif.presc == 3'h7
    && pre_r != '1 && !at_end && !cif.key_done |=> $stable(cnt_r))
    else $error("prescaler passed early tick");
endmodule // wdt_core

//--- hdl/wdt_core_if.sv
`timescale 1ns/10ps
// Control side to counter core
interface wdt_core_if;
  logic       tick;
  logic       key_done;
  logic [2:0] presc;
  logic       armed;
  logic       wrap;
  logic       rst_pin;
  modport ctrl (output tick, key_done, presc, input armed, wrap, rst_pin);
  modport core (input tick, key_done, presc, output armed, wrap, rst_pin);
endinterface

//--- hdl/wdt_pkg.sv
package wdt_pkg;
  typedef enum logic [1:0] {
    KEY_IDLE = 2'b01,
    KEY_HALF = 2'b10
  } key_state_e;
  typedef logic [3:0] event_t;
  typedef logic [9:0] reg_idx_t;
endpackage

//--- hdl/wdt_regs.svh
`ifndef WDT_REGS_SVH
`define WDT_REGS_SVH
// Register indexes; byte address is four times the index
`define WDT_IDX_SVC      10'h0a6
`define WDT_IDX_PRESC    10'h0a7
`define WDT_IDX_STAT     10'h0a8
`define WDT_IDX_ICLR     10'h0a9
`define WDT_IDX_IEN      10'h0aa
// Service key bytes
`define WDT_KEY_FIRST    8'h1e
`define WDT_KEY_SECOND   8'he1
// Counter and pulse figures
`define WDT_TERMINAL     14'h3fff
`define WDT_PULSE_TICKS  7'h60
`define WDT_PRESC_RST    3'h0
// Status bit positions
`define WDT_EV_ARM       0
`define WDT_EV_SERVICE   1
`define WDT_EV_ABANDON   2
`define WDT_EV_OVERFLOW  3
`define WDT_ST_ARMED     4
`define WDT_ST_PULSE     5
// Bus responses
`define WDT_RESP_OKAY    2'h0
`define WDT_RESP_SLVERR  2'h2
`endif

//--- hdl/wdt_top.sv
`timescale 1ns/10ps
`include "wdt_regs.svh"
// Summary of operation
// - Watchdog is idle after every reset until the key sequence arms it.
// - Writing 1E then E1 to the service register arms the watchdog.
// - Armed, the 14-bit counter advances once per 2^n machine cycles at prescale setting n.
// - Armed, only reset or its own overflow stops it.
// - Counter reaching 3FFF overflows and resets the device.
// - Each complete key pair restarts the counter from zero.
// - Overflow drives the reset pin high for 96 machine-cycle ticks.
// - Service register is write-only; counter never readable or writable.
// - A seven-stage prescaler ahead of the counter lengthens the time-out.
// - Prescale setting is frozen once armed, until the next reset or overflow.
module wdt_top
  import wdt_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output      logic              s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output      logic              s_axi_wready,
  output      logic [1:0]        s_axi_bresp,
  output      logic              s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output      logic              s_axi_arready,
  output      logic [31:0]       s_axi_rdata,
  output      logic [1:0]        s_axi_rresp,
  output      logic              s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic              machine_cycle_tick,
  output      logic              wdt_irq,
  output      logic              wdt_reset_out
);

  // ****************************************
  // Declarations
  // ****************************************
  wdt_core_if cif ();

  logic             awready_r;
  logic             wready_r;
  logic             bvalid_r;
  logic [1:0]       bresp_r;
  logic             arready_r;
  logic             rvalid_r;
  logic [31:0]      rdata_r;
  logic [1:0]       rresp_r;
  logic             irq_r;
  logic             aw_full_r;
  logic             w_full_r;
  reg_idx_t         widx_r;
  logic [7:0]       wbyte_r;
  logic             wlane_r;
  key_state_e       key_r;
  logic             key_done_r;
  logic [2:0]       presc_r;
  event_t           stat_r;
  event_t           ien_r;
  event_t           ev_set;
  event_t           ev_clr;
  logic             aw_hs;
  logic             w_hs;
  logic             wr_go;
  logic             ar_hs;
  logic             aw_full_nxt;
  logic             w_full_nxt;
  logic             svc_wr;
  reg_idx_t         ridx;

  // Word index out of a byte address
  function automatic reg_idx_t to_idx(input logic [ADDR_W-1:0] a);
    to_idx = a[11:2];
  endfunction

  // Decoder shared by the read and write paths
  function automatic logic mapped(input reg_idx_t i);
    mapped = (i == `WDT_IDX_SVC) || (i == `WDT_IDX_PRESC) || (i == `WDT_IDX_STAT)
          || (i == `WDT_IDX_ICLR) || (i == `WDT_IDX_IEN);
  endfunction

  // ****************************************
  // Write channel
  // ****************************************
  // Address and data may arrive in either order; each is held until both are in
  assign aw_hs       = s_axi_awvalid & awready_r;
  assign w_hs        = s_axi_wvalid & wready_r;
  assign wr_go       = aw_full_r & w_full_r & ~bvalid_r;
  assign aw_full_nxt = (aw_full_r | aw_hs) & ~wr_go;
  assign w_full_nxt  = (w_full_r | w_hs) & ~wr_go;

  // Hold flags and ready outputs
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_r <= 1'b0;
      w_full_r  <= 1'b0;
      awready_r <= 1'b0;
      wready_r  <= 1'b0;
    end else begin
      aw_full_r <= aw_full_nxt;
      w_full_r  <= w_full_nxt;
      awready_r <= ~aw_full_nxt;
      wready_r  <= ~w_full_nxt;
    end
  end

  // Captured write address and low data byte
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      widx_r  <= '0;
      wbyte_r <= 8'h0;
      wlane_r <= 1'b0;
    end else begin
      if (aw_hs) begin
        widx_r <= to_idx(s_axi_awaddr);
      end
      if (w_hs) begin
        wbyte_r <= s_axi_wdata[7:0];
        wlane_r <= s_axi_wstrb[0];
      end
    end
  end

  // Write response; unmapped words answer SLVERR
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_r <= 1'b0;
      bresp_r  <= `WDT_RESP_OKAY;
    end else if (wr_go) begin
      bvalid_r <= 1'b1;
      bresp_r  <= mapped(widx_r) ? `WDT_RESP_OKAY : `WDT_RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_r <= 1'b0;
    end
  end

  // Only the low byte lane reaches the 8-bit service register
  assign svc_wr = wr_go & wlane_r & (widx_r == `WDT_IDX_SVC);

  // ****************************************
  // Key sequence
  // ****************************************
  // Any byte but the expected one drops back to idle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      key_r      <= KEY_IDLE;
      key_done_r <= 1'b0;
    end else begin
      key_done_r <= 1'b0;
      if (svc_wr) begin
        case (key_r)
          KEY_IDLE: begin
            key_r <= (wbyte_r == `WDT_KEY_FIRST) ? KEY_HALF : KEY_IDLE;
          end
          KEY_HALF: begin
            key_r      <= KEY_IDLE;
            key_done_r <= (wbyte_r == `WDT_KEY_SECOND);
          end
          default: begin
            key_r <= KEY_IDLE;
          end
        endcase
      end
    end
  end

  // ****************************************
  // Prescale select
  // ****************************************
  // Frozen once armed, so a runaway program cannot stretch the time-out
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      presc_r <= `WDT_PRESC_RST;
    end else if (wr_go && wlane_r && widx_r == `WDT_IDX_PRESC && !cif.armed) begin
      presc_r <= wbyte_r[2:0];
    end
  end

  // ****************************************
  // Interrupt status
  // ****************************************
  // Events from the key logic and the core
  always_comb begin
    ev_set                   = '0;
    ev_set[`WDT_EV_ARM]      = key_done_r & ~cif.armed;
    ev_set[`WDT_EV_SERVICE]  = key_done_r & cif.armed;
    ev_set[`WDT_EV_ABANDON]  = svc_wr & (key_r == KEY_HALF) & (wbyte_r != `WDT_KEY_SECOND);
    ev_set[`WDT_EV_OVERFLOW] = cif.wrap;
  end

  assign ev_clr = (wr_go && wlane_r && widx_r == `WDT_IDX_ICLR) ? wbyte_r[3:0] : '0;

  // Sticky bits; a new event beats a clear in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stat_r <= '0;
    end else begin
      stat_r <= (stat_r & ~ev_clr) | ev_set;
    end
  end

  // Enable mask
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ien_r <= '0;
    end else if (wr_go && wlane_r && widx_r == `WDT_IDX_IEN) begin
      ien_r <= wbyte_r[3:0];
    end
  end

  // Level interrupt
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= |((stat_r & ~ev_clr | ev_set) & ien_r);
    end
  end

  // ****************************************
  // Read channel
  // ****************************************
  assign ar_hs = s_axi_arvalid & arready_r;
  assign ridx  = to_idx(s_axi_araddr);

  // One read at a time; ready returns once the data is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_r <= 1'b0;
      rvalid_r  <= 1'b0;
    end else if (ar_hs) begin
      arready_r <= 1'b0;
      rvalid_r  <= 1'b1;
    end else if (rvalid_r && s_axi_rready) begin
      arready_r <= 1'b1;
      rvalid_r  <= 1'b0;
    end else if (!rvalid_r) begin
      arready_r <= 1'b1;
    end
  end

  // Read data; write-only words and the counter never show
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rdata_r <= 32'h0;
      rresp_r <= `WDT_RESP_OKAY;
    end else if (ar_hs) begin
      rdata_r <= 32'h0;
      rresp_r <= mapped(ridx) ? `WDT_RESP_OKAY : `WDT_RESP_SLVERR;
      case (ridx)
        `WDT_IDX_PRESC: begin
          rdata_r[2:0] <= presc_r;
        end
        `WDT_IDX_STAT: begin
          rdata_r[3:0]           <= stat_r;
          rdata_r[`WDT_ST_ARMED] <= cif.armed;
          rdata_r[`WDT_ST_PULSE] <= cif.rst_pin;
        end
        `WDT_IDX_IEN: begin
          rdata_r[3:0] <= ien_r;
        end
        default: begin
          rdata_r <= 32'h0;
        end
      endcase
    end
  end

  // ****************************************
  // Core and outputs
  // ****************************************
  assign cif.tick     = machine_cycle_tick;
  assign cif.key_done = key_done_r;
  assign cif.presc    = presc_r;

  wdt_core #(
    .CNT_W (14),
    .PRE_W (7)
  ) u_core (
    .aclk    (aclk),
    .aresetn (aresetn),
    .cif     (cif.core)
  );

  assign s_axi_awready = awready_r;
  assign s_axi_wready  = wready_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rdata   = rdata_r;
  assign s_axi_rresp   = rresp_r;
  assign wdt_irq       = irq_r;
  assign wdt_reset_out = cif.rst_pin;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence first_key_s;
    key_r == KEY_IDLE && svc_wr && wbyte_r == `WDT_KEY_FIRST;
  endsequence

  sequence second_key_s;
    key_r == KEY_HALF && svc_wr && wbyte_r == `WDT_KEY_SECOND;
  endsequence

  first_key_a: assert property (first_key_s |=> key_r == KEY_HALF && !key_done_r)
    else $error("first key not taken");
  key_pair_a: assert property (second_key_s |=> key_done_r ##1 cif.armed)
    else $error("key pair did not arm or service");
  key_abandon_a: assert property (key_r == KEY_HALF && svc_wr
    && wbyte_r != `WDT_KEY_SECOND |=> key_r == KEY_IDLE && !key_done_r)
    else $error("wrong byte kept sequence");
  presc_lock_a: assert property (cif.armed |=> $stable(presc_r))
    else $error("prescale changed while armed");
  svc_read_a: assert property (ar_hs && ridx == `WDT_IDX_SVC |=> rdata_r == 32'h0)
    else $error("service register readable");
  irq_level_a: assert property ((|(stat_r & ien_r)) && ev_clr == '0 |=> irq_r)
    else $error("enabled status without interrupt");
  // Bus side: every issued write and accepted read is answered next cycle
  write_resp_a: assert property (wr_go |=> bvalid_r)
    else $error("write not answered");
  bad_addr_a: assert property (wr_go && !mapped(widx_r) |=> bresp_r == `WDT_RESP_SLVERR)
    else $error("unmapped write not refused");
  read_resp_a: assert property (ar_hs |=> rvalid_r && !arready_r)
    else $error("read not answered");
  // A stray byte with no sequence under way must not start or finish one
  stray_key_a: assert property (key_r == KEY_IDLE && svc_wr
    && wbyte_r != `WDT_KEY_FIRST |=> key_r == KEY_IDLE && !key_done_r)
    else $error("stray byte moved key sequence");
  ovf_status_a: assert property (cif.wrap |=> stat_r[`WDT_EV_OVERFLOW])
    else $error("overflow event not recorded");
endmodule // wdt_top

//--- tb/tb_hardware_watchdog_timer.sv
`timescale 1ns/10ps
`include "wdt_regs.svh"
module tb_hardware_watchdog_timer
  import wdt_pkg::*;
;
  // ***********************
  // Signals and instance
  // ***********************
  logic        aclk, aresetn, awvalid, wvalid, bvalid, bready, arvalid, rvalid, rready;
  logic        awready, wready, arready, tick, irq, rst_out;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [1:0]  bresp, rresp;
  logic [3:0]  wstrb;
  logic [31:0] rd;
  logic [1:0]  rsp;
  int          num_errors, n_checks, cyc, n;
  localparam logic [11:0] SVC = {`WDT_IDX_SVC, 2'b00};
  localparam logic [11:0] PRE = {`WDT_IDX_PRESC, 2'b00};
  localparam logic [11:0] STA = {`WDT_IDX_STAT, 2'b00};
  localparam logic [11:0] CLR = {`WDT_IDX_ICLR, 2'b00};
  localparam logic [11:0] IEN = {`WDT_IDX_IEN, 2'b00};
  localparam logic [1:0]  OK  = `WDT_RESP_OKAY;
  localparam logic [1:0]  ERR = `WDT_RESP_SLVERR;
  typedef struct packed {logic wr; logic [11:0] a; logic [7:0] d; logic [1:0] r;} row_s;
  // Data is the write value or, for a read, the value expected back
  row_s rows [9] = '{'{1'b0, SVC, 8'h00, OK}, '{1'b1, 12'h100, 8'h5a, ERR},
                     '{1'b0, 12'h100, 8'h00, ERR}, '{1'b1, PRE, 8'h05, OK},
                     '{1'b0, PRE, 8'h05, OK}, '{1'b1, PRE, 8'h00, OK},
                     '{1'b1, IEN, 8'h0f, OK}, '{1'b0, IEN, 8'h0f, OK},
                     '{1'b0, STA, 8'h00, OK}};

  wdt_top wdt_top_i (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .machine_cycle_tick(tick), .wdt_irq(irq),
    .wdt_reset_out(rst_out));

  // ***********************
  // Tasks
  // ***********************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  // Address and data offered together, each dropped once taken
  task automatic wr(input logic [11:0] a, input logic [7:0] d, output logic [1:0] r);
    @(posedge aclk);
    awaddr <= a; wdata <= {24'h0, d}; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask

  task automatic rdr(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    d = rdata; r = rresp;
    rready <= 1'b0;
  endtask

  task automatic key();
    wr(SVC, `WDT_KEY_FIRST, rsp);
    wr(SVC, `WDT_KEY_SECOND, rsp);
  endtask

  task automatic wait_rise(output int c);
    c = 0;
    do begin @(posedge aclk); c++; end while (rst_out !== 1'b1);
  endtask

  task automatic wrap_up();
    $display("checks %0d, errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // ***********************
  // Clock, reset, timeout
  // ***********************
  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end

  // Ceiling sits above the two full time-outs plus the servicing run
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 100000) begin
      num_errors++;
      wrap_up();
    end
  end

  // ***********************
  // Main sequence
  // ***********************
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, tick} = '0;
    {awaddr, araddr, wdata} = '0;
    wstrb = 4'h1;
    {num_errors, n_checks, cyc} = '0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    check({irq, rst_out, bvalid, rvalid}, 4'h0);
    foreach (rows[i]) begin
      if (rows[i].wr) wr(rows[i].a, rows[i].d, rsp);
      else begin
        rdr(rows[i].a, rd, rsp);
        check(rd, {24'h0, rows[i].d});
      end
      check(rsp, rows[i].r);
    end
    // Ticks run every cycle from here on; unarmed nothing may fire
    tick <= 1'b1;
    repeat (2000) @(posedge aclk);
    check(rst_out, 1'b0);
    // Broken pair leaves the block idle and raises the abandon event
    wr(SVC, `WDT_KEY_FIRST, rsp);
    wr(SVC, 8'h55, rsp);
    wr(SVC, `WDT_KEY_SECOND, rsp);
    rdr(STA, rd, rsp);
    check(rd, 32'h1 << `WDT_EV_ABANDON);
    check(irq, 1'b1);
    wr(CLR, 8'h0f, rsp);
    repeat (3) @(posedge aclk);
    check(irq, 1'b0);
    // Arm, then prove the prescale setting is frozen
    key();
    rdr(STA, rd, rsp);
    check(rd, (32'h1 << `WDT_EV_ARM) | (32'h1 << `WDT_ST_ARMED));
    wr(PRE, 8'h03, rsp);
    rdr(PRE, rd, rsp);
    check(rd, 32'h0);
    // Two halves longer together than one time-out, with a service between
    repeat (10000) @(posedge aclk);
    key();
    repeat (10000) @(posedge aclk);
    check(rst_out, 1'b0);
    wr(CLR, 8'h0f, rsp);
    key();
    wait_rise(n);
    check(n >= 16380 && n <= 16392, 1'b1);
    n = 0;
    while (rst_out === 1'b1) begin @(posedge aclk); n++; end
    check(n, 96);
    rdr(STA, rd, rsp);
    // The last service before the time-out also left its event behind
    check(rd, (32'h1 << `WDT_EV_SERVICE) | (32'h1 << `WDT_EV_OVERFLOW));
    check(irq, 1'b1);
    // Second reset after the overflow clears the status; one stage doubles the time-out
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rdr(STA, rd, rsp);
    check(rd, 32'h0);
    // A write without the low byte lane must leave the setting alone
    wstrb <= 4'h0;
    wr(PRE, 8'h07, rsp);
    check(rsp, OK);
    wstrb <= 4'h1;
    wr(PRE, 8'h01, rsp);
    rdr(PRE, rd, rsp);
    check(rd, 32'h1);
    key();
    wait_rise(n);
    check(n >= 32760 && n <= 32790, 1'b1);
    // Overflow disarms, so the deepest stage can be chosen before re-arming
    wr(PRE, 8'h07, rsp);
    rdr(PRE, rd, rsp);
    check(rd, 32'h7);
    key();
    repeat (300) @(posedge aclk);
    check(rst_out, 1'b0);
    rdr(STA, rd, rsp);
    check(rd[`WDT_ST_ARMED], 1'b1);
    wrap_up();
  end
endmodule // tb_hardware_watchdog_timer
